/* File: logic/smbcs_pkg.sv */
// Purpose: Shared constants of the two-wire configuration slave
// Assumes: 8-bit configuration bytes, 7-bit bus address
// Notes: Default bytes beyond byte 2 are plain zeros
package smbcs_pkg;
	localparam logic [6:0] SMBCS_SLAVE_ADDR = 7'h69;
	localparam int SMBCS_NUM_BYTES = 8;
	localparam logic [7:0] SMBCS_BYTE_COUNT = 8'h08;
	localparam int SMBCS_CMD_MODE_BIT = 7;
	localparam int SMBCS_UNLOCK_BIT = 0;
	localparam int SMBCS_WDIS_BIT = 7;
	localparam logic [7:0] SMBCS_DEF_BYTE0 = 8'h20;
	localparam logic [7:0] SMBCS_DEF_BYTE1 = 8'hff;
	localparam logic [7:0] SMBCS_DEF_BYTE2 = 8'hfe;
	localparam logic [7:0] SMBCS_DEF_OTHER = 8'h00;
	localparam int SMBCS_FIFO_DEPTH = 8;
	localparam int SMBCS_FIFO_WIDTH = 16;
	localparam int SMBCS_FW_MARK_BIT = 15;
	localparam int SMBCS_FW_OFF_LSB = 8;
	typedef enum {
		SMBCS_P_ADDR,
		SMBCS_P_CMD,
		SMBCS_P_CNT,
		SMBCS_P_WDATA
	} smbcs_phase_t;
	typedef enum {
		SMBCS_S_IDLE,
		SMBCS_S_RX,
		SMBCS_S_RX_END,
		SMBCS_S_ACK,
		SMBCS_S_TX,
		SMBCS_S_TX_ACK,
		SMBCS_S_TX_NEXT
	} smbcs_state_t;
endpackage : smbcs_pkg

/* File: logic/smbcs_fifo.sv */
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes: Full and empty come from a separate occupancy count
`timescale 1ns/1ns
module smbcs_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wptr_ff;
	logic [AW-1:0] rptr_ff;
	logic [AW:0] count_ff;
	wire push = i_in_valid && o_in_ready;
	wire pop = o_out_valid && i_out_ready;

	assign o_in_ready = (count_ff != (AW+1)'(DEPTH));
	assign o_out_valid = (count_ff != '0);
	assign o_out_data = mem_ff[rptr_ff];

	always_ff @(posedge i_clk) begin
		if (push) begin
			mem_ff[wptr_ff] <= i_in_data;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			wptr_ff <= '0;
			rptr_ff <= '0;
			count_ff <= '0;
		end else begin
			if (push) begin
				wptr_ff <= wptr_ff + 1'b1;
			end
			if (pop) begin
				rptr_ff <= rptr_ff + 1'b1;
			end
			if (push && !pop) begin
				count_ff <= count_ff + 1'b1;
			end else if (pop && !push) begin
				count_ff <= count_ff - 1'b1;
			end
		end
	end
endmodule : smbcs_fifo

/* File: logic/smbcs_slave.sv */
// Purpose: Two-wire configuration slave with lockable configuration bytes
// Assumes: Link clock comes from the host; data pin is open drain
// Notes: Written bytes pass a FIFO before they reach the configuration bytes
`timescale 1ns/1ns
module smbcs_slave import smbcs_pkg::*; (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_scl_clk,
	input wire logic i_sda,
	output logic o_sda,
	output logic o_sda_oe_n,
	input wire logic i_cfg_ready,
	output logic [SMBCS_NUM_BYTES*8-1:0] o_cfg
);
	// Link domain: data bit captured at each rising link clock edge
	logic lk_bit_ff;
	logic lk_tgl_ff;

	always_ff @(posedge i_scl_clk or posedge i_rst) begin
		if (i_rst) begin
			lk_bit_ff <= 1'b0;
			lk_tgl_ff <= 1'b0;
		end else begin
			lk_bit_ff <= i_sda;
			lk_tgl_ff <= ~lk_tgl_ff;
		end
	end

	// System domain synchronisers
	logic tgl_s1_ff;
	logic tgl_s2_ff;
	logic tgl_s3_ff;
	logic scl_s1_ff;
	logic scl_s2_ff;
	logic scl_s3_ff;
	logic sda_s1_ff;
	logic sda_s2_ff;
	logic sda_s3_ff;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			tgl_s1_ff <= 1'b0;
			tgl_s2_ff <= 1'b0;
			tgl_s3_ff <= 1'b0;
			scl_s1_ff <= 1'b1;
			scl_s2_ff <= 1'b1;
			scl_s3_ff <= 1'b1;
			sda_s1_ff <= 1'b1;
			sda_s2_ff <= 1'b1;
			sda_s3_ff <= 1'b1;
		end else begin
			tgl_s1_ff <= lk_tgl_ff;
			tgl_s2_ff <= tgl_s1_ff;
			tgl_s3_ff <= tgl_s2_ff;
			scl_s1_ff <= i_scl_clk;
			scl_s2_ff <= scl_s1_ff;
			scl_s3_ff <= scl_s2_ff;
			sda_s1_ff <= i_sda;
			sda_s2_ff <= sda_s1_ff;
			sda_s3_ff <= sda_s2_ff;
		end
	end

	// Bus events; the captured bit is stable while the toggle crosses
	wire bit_rx = tgl_s2_ff ^ tgl_s3_ff;
	wire rx_bit = lk_bit_ff;
	wire scl_fall = scl_s3_ff && !scl_s2_ff;
	wire start_det = scl_s2_ff && scl_s3_ff && sda_s3_ff && !sda_s2_ff;
	wire stop_det = scl_s2_ff && scl_s3_ff && !sda_s3_ff && sda_s2_ff;

	// Protocol engine state
	smbcs_state_t state_ff;
	smbcs_phase_t phase_ff;
	logic [2:0] cnt_ff;
	logic [7:0] sh_ff;
	logic [6:0] ptr_ff;
	logic blk_ff;
	logic tx_cnt_ff;
	logic drive_ff;
	logic rd_mode_ff;

	// Configuration bytes and lock state
	logic [7:0] cfg_ff [SMBCS_NUM_BYTES];
	logic unlock_ff;
	logic wen_eff_ff;
	logic wdis_ff;

	// Decoding of the byte that is completing
	wire [7:0] rx_byte = {sh_ff[6:0], rx_bit};
	wire addr_match = (rx_byte[7:1] == SMBCS_SLAVE_ADDR);
	wire cmd_block = !rx_byte[SMBCS_CMD_MODE_BIT];
	wire ptr_in_range = (ptr_ff < 7'(SMBCS_NUM_BYTES));
	wire [7:0] rd_byte = ptr_in_range ? cfg_ff[ptr_ff[2:0]] : 8'h00;
	wire [7:0] tx_byte = tx_cnt_ff ? SMBCS_BYTE_COUNT : rd_byte;

	// FIFO write side
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [SMBCS_FIFO_WIDTH-1:0] fifo_out_data;
	wire last_bit = (state_ff == SMBCS_S_RX) && bit_rx && (cnt_ff == 3'h7);
	wire push_mark = last_bit && (phase_ff == SMBCS_P_CNT);
	wire push_data = last_bit && (phase_ff == SMBCS_P_WDATA);
	wire fifo_push = push_mark || push_data;
	wire [SMBCS_FIFO_WIDTH-1:0] fifo_in_data = {push_mark, ptr_ff, rx_byte};

	// Acknowledge decision at the eighth bit of a received byte
	logic rx_ack;
	always_comb begin
		case (phase_ff)
			SMBCS_P_ADDR: rx_ack = addr_match;
			SMBCS_P_CMD: rx_ack = 1'b1;
			default: rx_ack = fifo_in_ready;
		endcase
	end

	// Next-state values of the protocol engine
	smbcs_state_t nxt_state;
	smbcs_phase_t nxt_phase;
	logic [2:0] nxt_cnt;
	logic [7:0] nxt_sh;
	logic [6:0] nxt_ptr;
	logic nxt_blk;
	logic nxt_tx_cnt;
	logic nxt_drive;
	logic nxt_rd_mode;

	always_comb begin
		nxt_state = state_ff;
		nxt_phase = phase_ff;
		nxt_cnt = cnt_ff;
		nxt_sh = sh_ff;
		nxt_ptr = ptr_ff;
		nxt_blk = blk_ff;
		nxt_tx_cnt = tx_cnt_ff;
		nxt_drive = drive_ff;
		nxt_rd_mode = rd_mode_ff;
		if (stop_det) begin
			nxt_state = SMBCS_S_IDLE;
			nxt_drive = 1'b0;
		end else if (start_det) begin
			// Plain or repeated start: expect an address byte
			nxt_state = SMBCS_S_RX;
			nxt_phase = SMBCS_P_ADDR;
			nxt_cnt = 3'h0;
			nxt_drive = 1'b0;
		end else begin
			case (state_ff)
				SMBCS_S_IDLE: begin
					nxt_drive = 1'b0;
				end
				SMBCS_S_RX: begin
					if (bit_rx) begin
						nxt_sh = rx_byte;
						nxt_cnt = cnt_ff + 3'h1;
						if (cnt_ff == 3'h7) begin
							nxt_state = rx_ack ? SMBCS_S_RX_END : SMBCS_S_IDLE;
						end
					end
				end
				SMBCS_S_RX_END: begin
					if (scl_fall) begin
						nxt_drive = 1'b1;
						nxt_state = SMBCS_S_ACK;
						case (phase_ff)
							SMBCS_P_ADDR: begin
								nxt_rd_mode = sh_ff[0];
								nxt_tx_cnt = blk_ff;
							end
							SMBCS_P_CMD: begin
								nxt_blk = !sh_ff[SMBCS_CMD_MODE_BIT];
								nxt_ptr = sh_ff[SMBCS_CMD_MODE_BIT] ? sh_ff[6:0] : 7'h00;
								nxt_phase = sh_ff[SMBCS_CMD_MODE_BIT] ? SMBCS_P_WDATA : SMBCS_P_CNT;
							end
							SMBCS_P_CNT: begin
								nxt_phase = SMBCS_P_WDATA;
							end
							default: begin
								nxt_ptr = ptr_ff + 7'h1;
							end
						endcase
					end
				end
				SMBCS_S_ACK: begin
					if (scl_fall) begin
						nxt_cnt = 3'h0;
						if (phase_ff == SMBCS_P_ADDR && !rd_mode_ff) begin
							nxt_drive = 1'b0;
							nxt_phase = SMBCS_P_CMD;
							nxt_state = SMBCS_S_RX;
						end else if (phase_ff == SMBCS_P_ADDR) begin
							nxt_drive = !tx_byte[7];
							nxt_sh = tx_byte;
							nxt_state = SMBCS_S_TX;
						end else begin
							nxt_drive = 1'b0;
							nxt_state = SMBCS_S_RX;
						end
					end
				end
				SMBCS_S_TX: begin
					if (scl_fall) begin
						nxt_cnt = cnt_ff + 3'h1;
						nxt_sh = {sh_ff[6:0], 1'b0};
						if (cnt_ff == 3'h7) begin
							nxt_drive = 1'b0;
							nxt_state = SMBCS_S_TX_ACK;
						end else begin
							nxt_drive = !sh_ff[6];
						end
					end
				end
				SMBCS_S_TX_ACK: begin
					if (bit_rx) begin
						if (rx_bit) begin
							nxt_state = SMBCS_S_IDLE;
						end else begin
							nxt_state = SMBCS_S_TX_NEXT;
							if (tx_cnt_ff) begin
								nxt_tx_cnt = 1'b0;
							end else begin
								nxt_ptr = ptr_ff + 7'h1;
							end
						end
					end
				end
				SMBCS_S_TX_NEXT: begin
					if (scl_fall) begin
						nxt_cnt = 3'h0;
						nxt_sh = tx_byte;
						nxt_drive = !tx_byte[7];
						nxt_state = SMBCS_S_TX;
					end
				end
				default: begin
					nxt_state = SMBCS_S_IDLE;
					nxt_drive = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_ff <= SMBCS_S_IDLE;
			phase_ff <= SMBCS_P_ADDR;
			cnt_ff <= 3'h0;
			sh_ff <= 8'h00;
			ptr_ff <= 7'h00;
			blk_ff <= 1'b0;
			tx_cnt_ff <= 1'b0;
			drive_ff <= 1'b0;
			rd_mode_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			phase_ff <= nxt_phase;
			cnt_ff <= nxt_cnt;
			sh_ff <= nxt_sh;
			ptr_ff <= nxt_ptr;
			blk_ff <= nxt_blk;
			tx_cnt_ff <= nxt_tx_cnt;
			drive_ff <= nxt_drive;
			rd_mode_ff <= nxt_rd_mode;
		end
	end

	// Written bytes wait here until the configuration side takes them
	smbcs_fifo #(
		.WIDTH(SMBCS_FIFO_WIDTH),
		.DEPTH(SMBCS_FIFO_DEPTH)
	) u_fifo (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_in_valid(fifo_push),
		.o_in_ready(fifo_in_ready),
		.i_in_data(fifo_in_data),
		.o_out_valid(fifo_out_valid),
		.i_out_ready(i_cfg_ready),
		.o_out_data(fifo_out_data)
	);

	// Apply side: decode of the entry leaving the FIFO
	wire apply = fifo_out_valid && i_cfg_ready;
	wire ap_mark = fifo_out_data[SMBCS_FW_MARK_BIT];
	wire [6:0] ap_off = fifo_out_data[SMBCS_FW_MARK_BIT-1:SMBCS_FW_OFF_LSB];
	wire [7:0] ap_data = fifo_out_data[7:0];
	wire ap_wr = apply && !ap_mark && !wdis_ff;
	wire ap_full = ap_wr && wen_eff_ff;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			unlock_ff <= 1'b0;
			wen_eff_ff <= 1'b0;
			wdis_ff <= 1'b0;
		end else begin
			if (apply && ap_mark) begin
				wen_eff_ff <= unlock_ff;
			end
			if (ap_wr && ap_off == 7'h00) begin
				unlock_ff <= ap_data[SMBCS_UNLOCK_BIT];
				if (ap_full && unlock_ff && ap_data[SMBCS_WDIS_BIT]) begin
					wdis_ff <= 1'b1;
				end
			end
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < SMBCS_NUM_BYTES; gi++) begin : g_byte
			localparam logic [7:0] DEF = (gi == 0) ? SMBCS_DEF_BYTE0 :
				(gi == 1) ? SMBCS_DEF_BYTE1 : (gi == 2) ? SMBCS_DEF_BYTE2 : SMBCS_DEF_OTHER;
			wire hit = ap_full && (ap_off == 7'(gi));
			wire unl_hit = (gi == 0) && ap_wr && (ap_off == 7'h00);
			always_ff @(posedge i_clk or posedge i_rst) begin
				if (i_rst) begin
					cfg_ff[gi] <= DEF;
				end else if (hit) begin
					cfg_ff[gi] <= ap_data;
				end else if (unl_hit) begin
					cfg_ff[gi][SMBCS_UNLOCK_BIT] <= ap_data[SMBCS_UNLOCK_BIT];
				end
			end
			always_ff @(posedge i_clk or posedge i_rst) begin
				if (i_rst) begin
					o_cfg[gi*8 +: 8] <= DEF;
				end else begin
					o_cfg[gi*8 +: 8] <= cfg_ff[gi];
				end
			end
		end
	endgenerate

	// Open-drain data pin: only ever pulled low
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_sda <= 1'b0;
			o_sda_oe_n <= 1'b1;
		end else begin
			o_sda <= 1'b0;
			o_sda_oe_n <= !drive_ff;
		end
	end
endmodule : smbcs_slave

/* File: tb/smbcs_slave_asserts.sv */
// Purpose: Port-level checks of the configuration slave
// Assumes: Link pins change on system clock falling edges
// Notes: Bound to every slave instance
`timescale 1ns/1ns
module smbcs_slave_asserts import smbcs_pkg::*; (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_scl_clk,
	input wire logic i_sda,
	input wire logic o_sda,
	input wire logic o_sda_oe_n,
	input wire logic i_cfg_ready,
	input wire logic [SMBCS_NUM_BYTES*8-1:0] o_cfg
);
	localparam logic [63:0] DEF_CFG = {{5{SMBCS_DEF_OTHER}}, SMBCS_DEF_BYTE2, SMBCS_DEF_BYTE1, SMBCS_DEF_BYTE0};
	logic [63:0] cfg_q_ff;
	logic [7:0] byte_chg;
	always_ff @(posedge i_clk) begin
		cfg_q_ff <= o_cfg;
	end
	for (genvar g = 0; g < 8; g++) begin : g_chg
		assign byte_chg[g] = cfg_q_ff[8*g+:8] != o_cfg[8*g+:8];
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	chk_reset_idle: assert property (disable iff (1'b0) i_rst |-> o_sda_oe_n && o_cfg == DEF_CFG)
		else $error("reset state wrong");
	chk_release_quiet: assert property ($past(i_rst) |-> o_sda_oe_n [*3])
		else $error("drive right after reset");
	chk_pull_only: assert property (o_sda == 1'b0)
		else $error("data pin driven high");
	chk_oe_scl_low: assert property (
		$changed(o_sda_oe_n) |-> !i_scl_clk && !$past(i_scl_clk) && !$past(i_scl_clk, 2))
		else $error("pin changed outside clock low");
	chk_drive_holds: assert property ($fell(o_sda_oe_n) |-> !o_sda_oe_n [*8])
		else $error("drive too short");
	chk_start_quiet: assert property ($fell(i_sda) && i_scl_clk && $past(i_scl_clk) |-> o_sda_oe_n [*4])
		else $error("drive after start");
	chk_cfg_stall: assert property ((!i_cfg_ready) [*4] |-> $stable(o_cfg))
		else $error("bytes changed while stalled");
	chk_one_byte: assert property ($onehot0(byte_chg))
		else $error("several bytes changed at once");
endmodule : smbcs_slave_asserts
bind smbcs_slave smbcs_slave_asserts chk_u (.i_clk(i_clk), .i_rst(i_rst), .i_scl_clk(i_scl_clk), .i_sda(i_sda),
	.o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n), .i_cfg_ready(i_cfg_ready), .o_cfg(o_cfg));

/* File: tb/smbcs_host_model.sv */
// Purpose: Bus host that drives link clock and data
// Assumes: Data wire has a pull-up, so 1 means released
// Notes: Link clock stays high between frames
`timescale 1ns/1ns
module smbcs_host_model (
	output logic o_scl,
	output logic o_sda_drv,
	input wire logic i_sda
);
	initial begin
		o_scl = 1'b1;
		o_sda_drv = 1'b1;
	end
	task bit_io(input logic b, output logic r);
		#40 o_sda_drv = b;
		#40 o_scl = 1'b1;
		#40 r = i_sda;
		#40 o_scl = 1'b0;
	endtask : bit_io
	// Start, or repeated start when the clock is low
	task start;
		if (!o_scl) begin
			#40 o_sda_drv = 1'b1;
			#40 o_scl = 1'b1;
		end
		#80 o_sda_drv = 1'b0;
		#80 o_scl = 1'b0;
	endtask : start
	task stop;
		#40 o_sda_drv = 1'b0;
		#40 o_scl = 1'b1;
		#80 o_sda_drv = 1'b1;
		#80;
	endtask : stop
	task send(input logic [7:0] v, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(v[i], r);
		bit_io(1'b1, r);
		ack = ~r;
	endtask : send
	task recv(input logic last, output logic [7:0] v);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			v[i] = r;
		end
		bit_io(last, r);
	endtask : recv
endmodule : smbcs_host_model

/* File: tb/smbus_config_slave_test.sv */
// Purpose: Self-checking bench of the configuration slave
// Assumes: Host model moves the link on clock falling edges
// Notes: Expected bytes are kept in exp_b
`timescale 1ns/1ns
module smbus_config_slave_test import smbcs_pkg::*;;
	typedef struct {
		logic [7:0] cmd;
		logic [7:0] val;
	} smbcs_row_t;
	logic i_clk;
	logic i_rst;
	logic i_cfg_ready;
	wire scl;
	wire sda_drv;
	wire o_sda;
	wire o_sda_oe_n;
	wire [63:0] o_cfg;
	wire sda_wire = sda_drv & (o_sda_oe_n | o_sda);
	int n_mismatch;
	int num_checks;
	int cyc;
	logic ack;
	logic [7:0] rd;
	logic [15:0] acks;
	logic [7:0] wd [8];
	logic [7:0] exp_b [8];
	smbcs_row_t rows [4];
	smbcs_slave dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_scl_clk(scl), .i_sda(sda_wire), .o_sda(o_sda),
		.o_sda_oe_n(o_sda_oe_n), .i_cfg_ready(i_cfg_ready), .o_cfg(o_cfg));
	smbcs_host_model host_u (.o_scl(scl), .o_sda_drv(sda_drv), .i_sda(sda_wire));
	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 40000) begin
			n_mismatch++;
			final_report();
		end
	end
	task chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	function automatic logic [63:0] exp_cfg;
		logic [63:0] v;
		for (int i = 0; i < 8; i++) v[8*i+:8] = exp_b[i];
		return v;
	endfunction : exp_cfg
	task final_report;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : final_report
	task wr_addr(input logic [7:0] a);
		host_u.start();
		host_u.send(a, ack);
	endtask : wr_addr
	task byte_wr(input logic [7:0] cmd, input logic [7:0] d);
		wr_addr(8'hd2);
		host_u.send(cmd, ack);
		host_u.send(d, ack);
		host_u.stop();
		repeat (4) @(negedge i_clk);
	endtask : byte_wr
	task blk_wr(input int n);
		wr_addr(8'hd2);
		acks = {15'h0, ack};
		host_u.send(8'h00, acks[1]);
		host_u.send(8'(n), acks[2]);
		for (int i = 0; i < n; i++) begin
			host_u.send(wd[i], ack);
			acks[i+3] = ack;
		end
		host_u.stop();
		repeat (4) @(negedge i_clk);
	endtask : blk_wr
	initial begin
		i_rst = 1'b1;
		i_cfg_ready = 1'b1;
		exp_b = '{0: SMBCS_DEF_BYTE0, 1: SMBCS_DEF_BYTE1, 2: SMBCS_DEF_BYTE2, default: SMBCS_DEF_OTHER};
		rows = '{'{8'h80, 8'h20}, '{8'h81, 8'hff}, '{8'h82, 8'hfe}, '{8'h89, 8'h00}};
		repeat (4) @(negedge i_clk);
		chk("reset bytes", exp_cfg(), o_cfg);
		chk("reset drive", 64'h1, 64'(o_sda_oe_n));
		i_rst = 1'b0;
		repeat (4) @(negedge i_clk);
		foreach (rows[i]) begin
			wr_addr(8'hd2);
			host_u.send(rows[i].cmd, ack);
			wr_addr(8'hd3);
			host_u.recv(1'b1, rd);
			host_u.stop();
			chk("byte read", 64'(rows[i].val), 64'(rd));
		end
		$display("reset and table tests done");
		byte_wr(8'h81, 8'h00);
		chk("locked ack", 64'h1, 64'(ack));
		chk("locked bytes", exp_cfg(), o_cfg);
		wr_addr(8'ha4);
		chk("foreign ack", 64'h0, 64'(ack));
		host_u.stop();
		wd[0] = 8'h01;
		blk_wr(1);
		exp_b[0] = 8'h21;
		chk("unlock acks", 64'h000f, 64'(acks));
		chk("unlock bytes", exp_cfg(), o_cfg);
		$display("lock tests done");
		i_cfg_ready = 1'b0;
		for (int i = 0; i < 8; i++) wd[i] = 8'h31 + 8'(2 * i);
		blk_wr(8);
		chk("full acks", 64'h03ff, 64'(acks));
		chk("stalled bytes", exp_cfg(), o_cfg);
		i_cfg_ready = 1'b1;
		repeat (12) @(negedge i_clk);
		for (int i = 0; i < 7; i++) exp_b[i] = wd[i];
		chk("drained bytes", exp_cfg(), o_cfg);
		wr_addr(8'hd2);
		host_u.send(8'h00, ack);
		wr_addr(8'hd3);
		host_u.recv(1'b0, rd);
		chk("count", 64'(SMBCS_BYTE_COUNT), 64'(rd));
		for (int i = 0; i < 8; i++) begin
			host_u.recv(i == 7, rd);
			chk("block read", 64'(exp_b[i]), 64'(rd));
		end
		host_u.stop();
		$display("block tests done");
		byte_wr(8'h87, 8'h5a);
		byte_wr(8'h8c, 8'h77);
		exp_b[7] = 8'h5a;
		chk("byte write", exp_cfg(), o_cfg);
		wd[0] = 8'h81;
		blk_wr(1);
		exp_b[0] = 8'h81;
		wd[0] = 8'h00;
		blk_wr(1);
		byte_wr(8'h81, 8'h00);
		chk("disabled ack", 64'h1, 64'(ack));
		chk("disabled bytes", exp_cfg(), o_cfg);
		$display("write disable test done");
		final_report();
	end
endmodule : smbus_config_slave_test
